// ---- adc_irq_pkg.sv ----
// package: register map, vector codes and carrier types for the result interrupt logic
package adc_irq_pkg;
  // ==========================================================
  // register byte offsets
  localparam logic [11:0] enable_offset = 12'h000;
  localparam logic [11:0] flags_offset = 12'h004;
  localparam logic [11:0] vector_offset = 12'h008;
  // ==========================================================
  // reset values
  localparam logic [15:0] enable_reset = 16'h0000;
  localparam logic [15:0] flags_reset = 16'h0000;
  // ==========================================================
  // vector codes
  localparam logic [15:0] vec_none = 16'h0000;
  localparam logic [15:0] vec_mem_overflow = 16'h0002;
  localparam logic [15:0] vec_time_overflow = 16'h0004;
  localparam logic [15:0] vec_flag_base = 16'h0006;
  localparam int slot_count = 16;

  // apb request from the master
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } apb_req_t;

  // apb answer to the master
  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } apb_rsp_t;

  // conversion engine events, one load and one access bit per result slot, plus one bit for each of the two overflows
  typedef struct packed {
    logic [15:0] slot_loaded;
    logic [15:0] slot_accessed;
    logic mem_overflow;
    logic time_overflow;
  } conv_events_t;
endpackage : adc_irq_pkg

// ---- adc_result_interrupt_logic.sv ----
// design: interrupt enables, result-ready flags and priority vector of a 12-bit adc
`timescale 1ns/10ps
// Overview of operation
// - sixteen enable bits reset to zero, and a set bit lets its flag request an interrupt.
// - a slot's result-ready flag sets whenever that slot is loaded with a new result.
// - a flag clears when its slot is accessed or when software writes zero to it, and flags reset to zero.
// - the vector reads zero when nothing is pending.
// - result-memory overflow reads 2 and ranks highest, conversion-time overflow reads 4 next.
// - flags 0 to 15 read 6 to 0x24 in steps of two, flag 0 first, flag 15 last.
module adc_result_interrupt_logic (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // apb slave
  input wire adc_irq_pkg::apb_req_t apb_req,
  output adc_irq_pkg::apb_rsp_t apb_rsp,
  // conversion engine
  input wire adc_irq_pkg::conv_events_t conv_events,
  // cpu interrupt request
  output logic irq
);

  // ==========================================================
  // reset release
  logic rst_meta_n;
  logic rst_sync_n;

  // two-stage release of the asynchronous reset
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_n <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_meta_n <= 1'b1;
      rst_sync_n <= rst_meta_n;
    end
  end

  // ==========================================================
  // bus decode
  logic [15:0] result_interrupt_enable;
  logic [15:0] result_interrupt_flags;
  logic [15:0] interrupt_vector;
  logic mem_overflow_pending;
  logic time_overflow_pending;
  wire access_phase = apb_req.psel && apb_req.penable && !apb_rsp.pready;
  wire hit_enable = apb_req.paddr == adc_irq_pkg::enable_offset;
  wire hit_flags = apb_req.paddr == adc_irq_pkg::flags_offset;
  wire hit_vector = apb_req.paddr == adc_irq_pkg::vector_offset;
  wire hit_any = hit_enable || hit_flags || hit_vector;
  wire wr_enable = access_phase && apb_req.pwrite && hit_enable;
  wire wr_flags = access_phase && apb_req.pwrite && hit_flags;
  wire rd_vector = access_phase && !apb_req.pwrite && hit_vector;
  wire [15:0] read_mux = hit_enable ? result_interrupt_enable :
                         hit_flags ? result_interrupt_flags :
                         hit_vector ? interrupt_vector : 16'h0000;

  // ==========================================================
  // priority encoder
  function automatic logic [15:0] encode_vector(input logic mem_ov, input logic time_ov,
                                               input logic [15:0] active);
    logic [15:0] code;
    code = adc_irq_pkg::vec_none;
    for (int i = adc_irq_pkg::slot_count - 1; i >= 0; i--) begin
      if (active[i]) begin
        code = adc_irq_pkg::vec_flag_base + 16'(2 * i);
      end
    end
    if (time_ov) begin
      code = adc_irq_pkg::vec_time_overflow;
    end
    if (mem_ov) begin
      code = adc_irq_pkg::vec_mem_overflow;
    end
    return code;
  endfunction : encode_vector

  wire [15:0] active_flags = result_interrupt_flags & result_interrupt_enable;
  wire [15:0] next_vector = encode_vector(mem_overflow_pending, time_overflow_pending, active_flags);
  wire next_irq = mem_overflow_pending || time_overflow_pending || (|active_flags);
  // a set in the same cycle beats any clear
  wire [15:0] flag_clear = conv_events.slot_accessed | (wr_flags ? ~apb_req.pwdata[15:0] : 16'h0000);
  wire [15:0] next_flags = (result_interrupt_flags & ~flag_clear) | conv_events.slot_loaded;
  // reading the vector while it shows an overflow acknowledges that overflow
  wire ack_mem = rd_vector && interrupt_vector == adc_irq_pkg::vec_mem_overflow;
  wire ack_time = rd_vector && interrupt_vector == adc_irq_pkg::vec_time_overflow;

  // ==========================================================
  // registers
  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      result_interrupt_enable <= adc_irq_pkg::enable_reset;
      result_interrupt_flags <= adc_irq_pkg::flags_reset;
    end else begin
      if (wr_enable) begin
        result_interrupt_enable <= apb_req.pwdata[15:0];
      end
      result_interrupt_flags <= next_flags;
    end
  end

  // overflow sources, set wins over acknowledge
  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      mem_overflow_pending <= 1'b0;
      time_overflow_pending <= 1'b0;
    end else begin
      mem_overflow_pending <= conv_events.mem_overflow || (mem_overflow_pending && !ack_mem);
      time_overflow_pending <= conv_events.time_overflow || (time_overflow_pending && !ack_time);
    end
  end

  // vector, request and bus answer
  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      interrupt_vector <= adc_irq_pkg::vec_none;
      irq <= 1'b0;
      apb_rsp <= '0;
    end else begin
      interrupt_vector <= next_vector;
      irq <= next_irq;
      apb_rsp.pready <= access_phase;
      apb_rsp.pslverr <= access_phase && !hit_any;
      apb_rsp.prdata <= access_phase && !apb_req.pwrite ? {16'h0000, read_mux} : 32'h0000_0000;
    end
  end

  // ==========================================================
  // checks
  property p_enable_blocks;
    @(posedge clock) disable iff (!rst_sync_n)
      (result_interrupt_enable == 16'h0000 && !mem_overflow_pending && !time_overflow_pending) |=> !irq;
  endproperty
  a_enable_blocks: assert property (p_enable_blocks) else $error("irq with all sources blocked");

  property p_flag_sets;
    @(posedge clock) disable iff (!rst_sync_n)
      conv_events.slot_loaded[0] |=> result_interrupt_flags[0];
  endproperty
  a_flag_sets: assert property (p_flag_sets) else $error("flag did not set on load");

  property p_access_clears;
    @(posedge clock) disable iff (!rst_sync_n)
      (conv_events.slot_accessed[3] && !conv_events.slot_loaded[3]) |=> !result_interrupt_flags[3];
  endproperty
  a_access_clears: assert property (p_access_clears) else $error("flag not cleared on access");

  property p_idle_zero;
    @(posedge clock) disable iff (!rst_sync_n)
      (!mem_overflow_pending && !time_overflow_pending && active_flags == 16'h0000) |=> interrupt_vector == 16'h0000;
  endproperty
  a_idle_zero: assert property (p_idle_zero) else $error("vector not zero when idle");

  property p_mem_first;
    @(posedge clock) disable iff (!rst_sync_n)
      mem_overflow_pending |=> interrupt_vector == 16'h0002;
  endproperty
  a_mem_first: assert property (p_mem_first) else $error("memory overflow not top");

  property p_time_next;
    @(posedge clock) disable iff (!rst_sync_n)
      (time_overflow_pending && !mem_overflow_pending) |=> interrupt_vector == 16'h0004;
  endproperty
  a_time_next: assert property (p_time_next) else $error("time overflow code wrong");

  property p_slot_codes;
    @(posedge clock) disable iff (!rst_sync_n)
      (!mem_overflow_pending && !time_overflow_pending && active_flags[0]) |=> interrupt_vector == 16'h0006;
  endproperty
  a_slot_codes: assert property (p_slot_codes) else $error("slot 0 code wrong");

  property p_last_code;
    @(posedge clock) disable iff (!rst_sync_n)
      (!mem_overflow_pending && !time_overflow_pending && active_flags == 16'h8000) |=> interrupt_vector == 16'h0024;
  endproperty
  a_last_code: assert property (p_last_code) else $error("slot 15 code wrong");

  property p_irq_tracks;
    @(posedge clock) disable iff (!rst_sync_n)
      irq == (interrupt_vector != 16'h0000);
  endproperty
  a_irq_tracks: assert property (p_irq_tracks) else $error("irq and vector disagree");

  // enable register takes exactly the written low half
  property p_enable_write;
    @(posedge clock) disable iff (!rst_sync_n)
      wr_enable |=> result_interrupt_enable == $past(apb_req.pwdata[15:0]);
  endproperty
  a_enable_write: assert property (p_enable_write) else $error("enable write not taken");

  // every loaded slot shows its flag one edge later
  property p_all_loads;
    @(posedge clock) disable iff (!rst_sync_n)
      (conv_events.slot_loaded != 16'h0000) |=>
        (result_interrupt_flags & $past(conv_events.slot_loaded)) == $past(conv_events.slot_loaded);
  endproperty
  a_all_loads: assert property (p_all_loads) else $error("loaded slot flag missing");

  // a load and an access in one cycle leave the flag set
  property p_set_wins;
    @(posedge clock) disable iff (!rst_sync_n)
      (conv_events.slot_loaded[2] && conv_events.slot_accessed[2]) |=> result_interrupt_flags[2];
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("clear beat set on flag 2");

  // writing zero to a flag bit clears it
  property p_write_clears;
    @(posedge clock) disable iff (!rst_sync_n)
      (wr_flags && !apb_req.pwdata[5] && !conv_events.slot_loaded[5]) |=> !result_interrupt_flags[5];
  endproperty
  a_write_clears: assert property (p_write_clears) else $error("software clear of flag 5 failed");

  // reading the memory overflow code drops that source
  property p_mem_ack;
    @(posedge clock) disable iff (!rst_sync_n)
      (ack_mem && !conv_events.mem_overflow) |=> !mem_overflow_pending;
  endproperty
  a_mem_ack: assert property (p_mem_ack) else $error("memory overflow not acknowledged");

  // flag 1 wins when flag 0 is quiet
  property p_flag_one_code;
    @(posedge clock) disable iff (!rst_sync_n)
      (!mem_overflow_pending && !time_overflow_pending && active_flags[1:0] == 2'b10) |=> interrupt_vector == 16'h0008;
  endproperty
  a_flag_one_code: assert property (p_flag_one_code) else $error("slot 1 code wrong");

  // any pending enabled source raises the request
  property p_irq_raised;
    @(posedge clock) disable iff (!rst_sync_n)
      (mem_overflow_pending || time_overflow_pending || active_flags != 16'h0000) |=> irq;
  endproperty
  a_irq_raised: assert property (p_irq_raised) else $error("irq low with source pending");

endmodule : adc_result_interrupt_logic

// ---- conv_engine.sv ----
// partner: conversion engine issuing one-cycle event pulses
`timescale 1ns/10ps
module conv_engine (
  // clock
  input wire logic clock,
  // events toward the interrupt logic
  output adc_irq_pkg::conv_events_t ev
);
  initial ev = '0;
  // one-cycle pulse on the chosen events
  task automatic pulse(input logic [15:0] ld, input logic [15:0] ac, input logic mo, input logic tov);
    @(posedge clock);
    ev <= '{ld, ac, mo, tov};
    @(posedge clock);
    ev <= '0;
  endtask : pulse
endmodule : conv_engine

// ---- tb.sv ----
// testbench: apb master, reference model and scenarios for the result interrupt logic
`timescale 1ns/10ps
module tb;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  adc_irq_pkg::apb_req_t req = '0;
  adc_irq_pkg::apb_rsp_t rsp;
  adc_irq_pkg::conv_events_t ev;
  logic irq;
  logic [31:0] seed = 32'h00010dd5;
  logic [15:0] m_en = 16'h0000;
  logic [15:0] m_fl = 16'h0000;
  logic m_mo = 1'b0;
  logic m_to = 1'b0;
  logic [31:0] r;
  logic e;
  int err_total = 0;
  int total_checks = 0;
  int cycles = 0;
  // ==========================================================
  // clock, design and partner
  always #5 clock = ~clock;
  adc_result_interrupt_logic i_dut (.clock(clock), .rst_n(rst_n), .apb_req(req), .apb_rsp(rsp),
    .conv_events(ev), .irq(irq));
  conv_engine i_eng (.clock(clock), .ev(ev));
  // hang guard
  always @(posedge clock) begin
    cycles++;
    if (cycles == 5000) begin
      err_total++;
      finish_test();
    end
  end
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  // model vector: overflows first, then lowest enabled flag
  function automatic logic [15:0] vec_f();
    if (m_mo) return 16'h0002;
    if (m_to) return 16'h0004;
    for (int k = 0; k < 16; k++) if (m_fl[k] & m_en[k]) return 16'h0006 + 16'(2 * k);
    return 16'h0000;
  endfunction : vec_f
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : chk
  // one apb transfer, held until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    req <= '{1'b1, 1'b0, w, a, d};
    @(posedge clock);
    req.penable <= 1'b1;
    do @(posedge clock); while (rsp.pready !== 1'b1);
    r = rsp.prdata;
    e = rsp.pslverr;
    req <= '0;
    @(posedge clock);
  endtask : apb
  // read vector in a loop, clearing each shown source the documented way
  task automatic drain();
    logic [15:0] v;
    repeat (20) begin
      v = vec_f();
      chk({31'h0, irq}, {31'h0, v != 16'h0000});
      apb(1'b0, adc_irq_pkg::vector_offset, 32'h0);
      chk(r, {16'h0, v});
      if (v == 16'h0000) break;
      if (v == 16'h0002) m_mo = 1'b0;
      else if (v == 16'h0004) m_to = 1'b0;
      else begin
        i_eng.pulse(16'h0, 16'h1 << ((v - 16'h0006) >> 1), 1'b0, 1'b0);
        m_fl[(v - 16'h0006) >> 1] = 1'b0;
      end
      repeat (2) @(posedge clock);
    end
  endtask : drain
  // ==========================================================
  // main sequence
  initial begin
    repeat (16) @(posedge clock);
    rst_n <= 1'b1;
    repeat (3) @(posedge clock);
    apb(1'b0, adc_irq_pkg::enable_offset, 32'h0);
    chk(r, 32'h0);
    apb(1'b0, adc_irq_pkg::flags_offset, 32'h0);
    chk(r, 32'h0);
    drain();
    m_en = 16'(rnd());
    apb(1'b1, adc_irq_pkg::enable_offset, {16'h0, m_en});
    apb(1'b0, adc_irq_pkg::enable_offset, 32'h0);
    chk(r, {16'h0, m_en});
    for (int i = 0; i < 4; i++) begin
      m_fl |= 16'(rnd());
      i_eng.pulse(m_fl, 16'h0, i[0], i[1]);
      m_mo |= i[0];
      m_to |= i[1];
      @(posedge clock);
      apb(1'b0, adc_irq_pkg::flags_offset, 32'h0);
      chk(r, {16'h0, m_fl});
      drain();
      m_en = 16'hffff;
      apb(1'b1, adc_irq_pkg::enable_offset, 32'h0000ffff);
      drain();
    end
    m_fl = 16'h8001;
    i_eng.pulse(m_fl, 16'h0, 1'b0, 1'b0);
    apb(1'b1, adc_irq_pkg::flags_offset, 32'h00008000);
    m_fl = 16'h8000;
    apb(1'b0, adc_irq_pkg::flags_offset, 32'h0);
    chk(r, 32'h00008000);
    m_fl[2] = 1'b1;
    i_eng.pulse(16'h0004, 16'h0004, 1'b0, 1'b0);
    @(posedge clock);
    apb(1'b0, adc_irq_pkg::flags_offset, 32'h0);
    chk(r, {16'h0, m_fl});
    apb(1'b1, adc_irq_pkg::flags_offset, 32'h0000ffff);
    apb(1'b0, adc_irq_pkg::flags_offset, 32'h0);
    chk(r, {16'h0, m_fl});
    apb(1'b1, adc_irq_pkg::enable_offset, 32'h0);
    m_en = 16'h0000;
    @(posedge clock);
    drain();
    apb(1'b1, adc_irq_pkg::vector_offset, 32'h0000ffff);
    apb(1'b0, adc_irq_pkg::vector_offset, 32'h0);
    chk(r, 32'h0);
    apb(1'b0, 12'h00c, 32'h0);
    chk({r[30:0], e}, 32'h1);
    finish_test();
  end
  task automatic finish_test();
    $display("checks %0d, errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : finish_test
endmodule : tb
